// ===== fsr_defs.svh
// Opcodes, field positions, reset values and timing counts for the security-register sequencer
// Function
// RL1: Status reads and reset accepted during pause
// RL2: Resume accepted only when paused, not busy
// RL3: Resume clears pause, raises busy quickly
// RL4: Otherwise resume is ignored entirely
// RL5: Resume ignored after power loss
// RL6: Host waits before pausing after resume
// RL7: Security erase needs write enable latch
// RL8: Address fields select register one to three
// RL9: Erase discarded unless exact length
// RL10: Timed erase holds busy, then clears latch
// RL11: Locked register ignores erase
// RL12: Program needs latch, max 256 bytes
// RL13: Locked register ignores program
// RL14: Read: address, dummy byte, MSB-first out
// RL15: Read address wraps FFh to 00h
// RL16: Read streams until chip select rises
// RL17: Read ignored while busy
// RL18: Reset needs 66h then 99h directly
// RL19: Reset aborts and restores power-on defaults
// RL20: No instruction during reset recovery
// RL21: Host checks busy and pause first
// RL22: Pause flags at status bits 15, 10
// RL23: Opcode and address shifted MSB first
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH
`define FSR_OP_RDSR1 8'h05
`define FSR_OP_RDSR2 8'h35
`define FSR_OP_RDSR3 8'h25
`define FSR_OP_ENRST 8'h66
`define FSR_OP_DORST 8'h99
`define FSR_OP_RESUME 8'h7A
`define FSR_OP_SECERASE 8'h44
`define FSR_OP_SECPROG 8'h42
`define FSR_OP_SECREAD 8'h48
`define FSR_OP_WREN 8'h06
`define FSR_OP_WRDI 8'h04
`define FSR_CNT_OPCODE 5'h01
`define FSR_CNT_ERASE 5'h04
`define FSR_NUM_ADDR_LAST 5'h03
`define FSR_NUM_READ_FIRST 5'h05
`define FSR_SR2_PROG_PAUSED 7
`define FSR_SR2_ERASE_PAUSED 2
`define FSR_SR2_LOCK_LSB 3
`define FSR_SR3_WRAP_LSB 4
`define FSR_WRAP_RST 3'h0
`define FSR_CONT_MODE_RST 8'h00
`define FSR_CLK_PERIOD_NS 40
`define FSR_RESUME_WIP_NS 200
`define FSR_RESUME_WIP_CYC ((`FSR_RESUME_WIP_NS) / (`FSR_CLK_PERIOD_NS))
`endif

// ===== fsr_pkg.sv
// Types shared by the security-register sequencer
package fsr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ERASE = 3'b001,
		ST_PROG = 3'b010,
		ST_ARRAY = 3'b011,
		ST_RECOVER = 3'b100
	} fsr_state_t;
	typedef struct packed {
		logic [4:0] num;
		logic [7:0] data;
	} fsr_rxev_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} fsr_txword_t;
	typedef struct packed {
		logic refuse;
		logic [7:0] sr1;
		logic [7:0] sr2;
		logic [7:0] sr3;
	} fsr_status_t;
endpackage

// ===== fsr_sync.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module fsr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== fsr_secreg_seq.sv
// Serial flash command sequencer: security registers, resume and software reset
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defs.svh"
module fsr_secreg_seq #(
	parameter int ERASE_CYCLES = 20000,
	parameter int PROG_CYCLES = 5000,
	parameter int RST_CYCLES = 5000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output logic spiMisoO,
	output logic spiMisoOe,
	input wire logic pauseProgram,
	input wire logic pauseErase,
	input wire logic powerLoss,
	input wire logic arrayOpDone,
	input wire logic [2:0] securityLockBits,
	output logic arrayResume,
	output logic operationInProgress,
	output logic writeEnableLatch,
	output logic programPausedFlag,
	output logic erasePausedFlag,
	output logic [2:0] wrapSettingBits,
	output logic [7:0] continuousReadModeBits,
	output logic resetBusy
);
	localparam int ResumeCyc = `FSR_RESUME_WIP_CYC;

	function automatic logic [1:0] secSel(input logic [23:0] a);
		secSel = 2'h0;
		if (a[23:16] == 8'h00 && a[11:9] == 3'h0 && a[15:12] != 4'h0 && a[15:12] <= 4'h3)
			secSel = a[13:12];
	endfunction

	function automatic logic [10:0] memIdx(input logic [1:0] sel, input logic [8:0] a);
		memIdx = {sel - 2'h1, a};
	endfunction

	// Link domain: shifter on the host serial clock, cleared while chip select is high
	logic linkRst_n;
	logic [2:0] bitCnt_q;
	logic [6:0] rxSh_q;
	logic [4:0] byteNum_q;
	logic [7:0] linkOp_q;
	logic [7:0] txSh_q;
	logic txOe_q;
	logic rxTgl_q;
	logic loadTgl_q;
	fsr_pkg::fsr_rxev_t rxEv_q;
	fsr_pkg::fsr_txword_t txWord_q;
	fsr_pkg::fsr_status_t status_q;
	logic isStatOp;
	logic loadNow;

	assign linkRst_n = rst_n & ~spiCsN;
	assign isStatOp = linkOp_q == `FSR_OP_RDSR1 || linkOp_q == `FSR_OP_RDSR2 || linkOp_q == `FSR_OP_RDSR3;
	assign loadNow = bitCnt_q == 3'h0 && byteNum_q >= `FSR_NUM_READ_FIRST && linkOp_q == `FSR_OP_SECREAD;

	// RL23: MSB-first shift in
	always_ff @(posedge spiClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			bitCnt_q <= 3'h0;
			rxSh_q <= 7'h00;
			byteNum_q <= 5'h00;
			linkOp_q <= 8'h00;
		end
		else
		begin
			bitCnt_q <= bitCnt_q + 3'h1;
			rxSh_q <= {rxSh_q[5:0], spiMosi};
			if (bitCnt_q == 3'h7)
			begin
				if (byteNum_q != 5'h1F)
					byteNum_q <= byteNum_q + 5'h01;
				if (byteNum_q == 5'h00)
					linkOp_q <= {rxSh_q, spiMosi};
			end
		end
	end

	// Byte events survive the frame end so the core sees the last one
	always_ff @(posedge spiClk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxEv_q <= '0;
			rxTgl_q <= 1'b0;
		end
		else if (bitCnt_q == 3'h7)
		begin
			rxEv_q <= '{num: byteNum_q, data: {rxSh_q, spiMosi}};
			rxTgl_q <= ~rxTgl_q;
		end
	end

	// RL14: data out on falling edges, MSB first
	always_ff @(negedge spiClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			txSh_q <= 8'h00;
			txOe_q <= 1'b0;
		end
		else if (bitCnt_q == 3'h0 && byteNum_q != 5'h00 && isStatOp && !status_q.refuse)
		begin
			// RL1: status bytes go out at once, busy or paused
			txSh_q <= linkOp_q == `FSR_OP_RDSR1 ? status_q.sr1 :
				linkOp_q == `FSR_OP_RDSR2 ? status_q.sr2 : status_q.sr3;
			txOe_q <= 1'b1;
		end
		else if (loadNow && txWord_q.valid)
		begin
			txSh_q <= txWord_q.data;
			txOe_q <= 1'b1;
		end
		else
			txSh_q <= {txSh_q[6:0], 1'b0};
	end

	always_ff @(negedge spiClk or negedge rst_n)
	begin
		if (!rst_n)
			loadTgl_q <= 1'b0;
		else if (loadNow && txWord_q.valid)
			loadTgl_q <= ~loadTgl_q;
	end

	assign spiMisoO = txSh_q[7];
	assign spiMisoOe = txOe_q & ~spiCsN;

	// Core domain: crossings
	logic [2:0] syncQ;
	logic csD_q;
	logic csD2_q;
	logic rxTglD_q;
	logic loadTglD_q;
	logic rxEv;
	logic loadEv;
	logic frameEnd;

	fsr_sync #(.W(3)) uSync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d({~spiCsN, rxTgl_q, loadTgl_q}),
		.q(syncQ)
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			csD_q <= 1'b0;
			csD2_q <= 1'b0;
			rxTglD_q <= 1'b0;
			loadTglD_q <= 1'b0;
		end
		else
		begin
			csD_q <= syncQ[2];
			csD2_q <= csD_q;
			rxTglD_q <= syncQ[1];
			loadTglD_q <= syncQ[0];
		end
	end

	assign rxEv = syncQ[1] ^ rxTglD_q;
	assign loadEv = syncQ[0] ^ loadTglD_q;
	// Frame end lags the last byte event by at least one cycle, so that byte is counted first
	assign frameEnd = csD2_q & ~csD_q;

	// Command capture
	logic [7:0] op_q;
	logic [4:0] cnt_q;
	logic [15:0] addrHi_q;
	logic [23:0] fullAddr;
	logic [1:0] sel_q;
	logic [8:0] wrAddr_q;
	logic progOk_q;

	assign fullAddr = {addrHi_q, rxEv_q.data};

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_q <= 8'h00;
			cnt_q <= 5'h00;
			addrHi_q <= 16'h0000;
			sel_q <= 2'h0;
		end
		else if (frameEnd)
			cnt_q <= 5'h00;
		else if (rxEv)
		begin
			cnt_q <= rxEv_q.num + 5'h01;
			if (rxEv_q.num == 5'h00)
				op_q <= rxEv_q.data;
			else if (rxEv_q.num < `FSR_NUM_ADDR_LAST)
				addrHi_q <= {addrHi_q[7:0], rxEv_q.data};
			else if (rxEv_q.num == `FSR_NUM_ADDR_LAST)
				// RL8: register select from address fields
				sel_q <= secSel(fullAddr);
		end
	end

	// Sequencer state
	fsr_pkg::fsr_state_t state_q;
	logic [23:0] timer_q;
	logic [8:0] eraseIdx_q;
	logic wel_q;
	logic progPaused_q;
	logic erasePaused_q;
	logic stale_q;
	logic armed_q;
	logic [2:0] wrap_q;
	logic [7:0] contMode_q;
	logic resumePulse_q;
	logic idle;
	logic busy;
	logic paused;
	logic oneByte;
	logic doResume;
	logic rstAccept;
	logic doErase;
	logic doProg;

	assign idle = state_q == fsr_pkg::ST_IDLE;
	assign busy = state_q == fsr_pkg::ST_ERASE || state_q == fsr_pkg::ST_PROG || state_q == fsr_pkg::ST_ARRAY;
	assign paused = progPaused_q | erasePaused_q;
	assign oneByte = frameEnd && cnt_q == `FSR_CNT_OPCODE;
	// RL2 RL4: resume only when paused and idle
	assign doResume = oneByte && op_q == `FSR_OP_RESUME && idle && paused && !stale_q;
	// RL18: reset only straight after the arming opcode
	assign rstAccept = oneByte && op_q == `FSR_OP_DORST && armed_q && state_q != fsr_pkg::ST_RECOVER;
	// RL7 RL9 RL11: erase needs latch, exact length, unlocked register
	assign doErase = frameEnd && idle && op_q == `FSR_OP_SECERASE && cnt_q == `FSR_CNT_ERASE && wel_q &&
		sel_q != 2'h0 && !securityLockBits[sel_q - 2'h1];
	assign doProg = frameEnd && op_q == `FSR_OP_SECPROG && progOk_q && cnt_q > `FSR_CNT_ERASE;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= fsr_pkg::ST_IDLE;
			timer_q <= 24'h000000;
			eraseIdx_q <= 9'h000;
			resumePulse_q <= 1'b0;
		end
		else
		begin
			resumePulse_q <= 1'b0;
			if (rstAccept)
			begin
				// RL19: abort whatever runs
				state_q <= fsr_pkg::ST_RECOVER;
				timer_q <= 24'(RST_CYCLES);
			end
			else if (doResume)
			begin
				// RL3: busy again next cycle, array op continues
				state_q <= fsr_pkg::ST_ARRAY;
				resumePulse_q <= 1'b1;
			end
			else if (doErase)
			begin
				// RL10: self-timed erase
				state_q <= fsr_pkg::ST_ERASE;
				timer_q <= 24'(ERASE_CYCLES);
				eraseIdx_q <= 9'h000;
			end
			else if (doProg)
			begin
				state_q <= fsr_pkg::ST_PROG;
				timer_q <= 24'(PROG_CYCLES);
			end
			else if (state_q == fsr_pkg::ST_ARRAY && (arrayOpDone || pauseProgram || pauseErase))
				state_q <= fsr_pkg::ST_IDLE;
			else if (state_q == fsr_pkg::ST_ERASE || state_q == fsr_pkg::ST_PROG || state_q == fsr_pkg::ST_RECOVER)
			begin
				eraseIdx_q <= eraseIdx_q + 9'h001;
				if (timer_q <= 24'h000001)
					state_q <= fsr_pkg::ST_IDLE;
				else
					timer_q <= timer_q - 24'h000001;
			end
		end
	end

	// Status flags and volatile settings
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wel_q <= 1'b0;
			progPaused_q <= 1'b0;
			erasePaused_q <= 1'b0;
			stale_q <= 1'b0;
			armed_q <= 1'b0;
			wrap_q <= `FSR_WRAP_RST;
			contMode_q <= `FSR_CONT_MODE_RST;
		end
		else if (rstAccept)
		begin
			// RL19: back to power-on values
			wel_q <= 1'b0;
			progPaused_q <= 1'b0;
			erasePaused_q <= 1'b0;
			stale_q <= 1'b0;
			armed_q <= 1'b0;
			wrap_q <= `FSR_WRAP_RST;
			contMode_q <= `FSR_CONT_MODE_RST;
		end
		else
		begin
			// RL18: any other opcode disarms
			if (frameEnd && cnt_q != 5'h00 && state_q != fsr_pkg::ST_RECOVER)
				armed_q <= op_q == `FSR_OP_ENRST && cnt_q == `FSR_CNT_OPCODE;
			// RL20: nothing else accepted during recovery
			if (oneByte && idle && op_q == `FSR_OP_WREN)
				wel_q <= 1'b1;
			else if ((oneByte && idle && op_q == `FSR_OP_WRDI) ||
				((idle || state_q == fsr_pkg::ST_ARRAY) && (pauseProgram || pauseErase)))
				wel_q <= 1'b0;
			else if ((state_q == fsr_pkg::ST_ERASE || state_q == fsr_pkg::ST_PROG) && timer_q <= 24'h000001)
				// RL10: latch drops when the timed cycle ends
				wel_q <= 1'b0;
			// RL22: pause flags, set from idle or the resumed op, cleared on resume
			if (doResume)
			begin
				progPaused_q <= 1'b0;
				erasePaused_q <= 1'b0;
			end
			else if ((idle || state_q == fsr_pkg::ST_ARRAY) && pauseProgram)
				progPaused_q <= 1'b1;
			else if ((idle || state_q == fsr_pkg::ST_ARRAY) && pauseErase)
				erasePaused_q <= 1'b1;
			// RL5: a pause cut by power loss cannot resume
			if (powerLoss && paused)
				stale_q <= 1'b1;
			else if (pauseProgram || pauseErase)
				stale_q <= 1'b0;
		end
	end

	// Security register storage
	logic [7:0] secMem [0:1535];
	logic [8:0] rdAddr_q;

	always_ff @(posedge core_clk)
	begin
		if (state_q == fsr_pkg::ST_ERASE && eraseIdx_q == 9'h000)
			// RL10: whole register in the first erase cycle, any timer length
			for (int i = 0; i < 512; i++)
				secMem[memIdx(sel_q, 9'(i))] <= 8'hFF;
		else if (rxEv && rxEv_q.num > `FSR_NUM_ADDR_LAST && op_q == `FSR_OP_SECPROG && progOk_q)
			// RL12: program only clears bits of erased cells
			secMem[memIdx(sel_q, wrAddr_q)] <= secMem[memIdx(sel_q, wrAddr_q)] & rxEv_q.data;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			progOk_q <= 1'b0;
			wrAddr_q <= 9'h000;
		end
		else if (frameEnd)
			progOk_q <= 1'b0;
		else if (rxEv && rxEv_q.num == `FSR_NUM_ADDR_LAST && op_q == `FSR_OP_SECPROG)
		begin
			// RL13: locked or unlatched program is ignored
			progOk_q <= idle && wel_q && secSel(fullAddr) != 2'h0 && !securityLockBits[secSel(fullAddr) - 2'h1];
			wrAddr_q <= fullAddr[8:0];
		end
		else if (rxEv && rxEv_q.num > `FSR_NUM_ADDR_LAST)
			// RL12: at most one 256-byte page per operation
			wrAddr_q <= {wrAddr_q[8], wrAddr_q[7:0] + 8'h01};
	end

	// Read stream toward the link
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txWord_q <= '0;
			rdAddr_q <= 9'h000;
		end
		else if (frameEnd || rstAccept)
			// RL16: stream ends with the frame
			txWord_q.valid <= 1'b0;
		else if (rxEv && rxEv_q.num == `FSR_NUM_ADDR_LAST && op_q == `FSR_OP_SECREAD)
		begin
			// RL17: busy or recovering device ignores reads
			txWord_q.valid <= idle && secSel(fullAddr) != 2'h0;
			txWord_q.data <= secMem[memIdx(secSel(fullAddr), fullAddr[8:0])];
			rdAddr_q <= {fullAddr[8], fullAddr[7:0] + 8'h01};
		end
		else if (loadEv && txWord_q.valid)
		begin
			// RL15: low byte wraps inside the register
			txWord_q.data <= secMem[memIdx(sel_q, rdAddr_q)];
			rdAddr_q <= {rdAddr_q[8], rdAddr_q[7:0] + 8'h01};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			status_q <= '0;
		else
		begin
			status_q.refuse <= state_q == fsr_pkg::ST_RECOVER;
			status_q.sr1 <= {6'h00, wel_q, busy};
			status_q.sr2 <= {progPaused_q, 1'b0, securityLockBits, erasePaused_q, 2'h0};
			status_q.sr3 <= {1'b0, wrap_q, 4'h0};
		end
	end

	assign arrayResume = resumePulse_q;
	assign operationInProgress = busy;
	assign writeEnableLatch = wel_q;
	assign programPausedFlag = progPaused_q;
	assign erasePausedFlag = erasePaused_q;
	assign wrapSettingBits = wrap_q;
	assign continuousReadModeBits = contMode_q;
	assign resetBusy = state_q == fsr_pkg::ST_RECOVER;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_resume_wip_raise: assert property (doResume |-> ##[1:ResumeCyc] (busy && !paused)) // RL3
		else $error("resume did not raise busy in time");
	a_resume_ignored: assert property (oneByte && op_q == `FSR_OP_RESUME && (!paused || busy) |=> !arrayResume) // RL4
		else $error("resume acted while not paused or busy");
	a_resume_stale: assert property (oneByte && op_q == `FSR_OP_RESUME && stale_q |=> !arrayResume) // RL5
		else $error("resume acted after power loss");
	a_erase_wel_need: assert property (frameEnd && op_q == `FSR_OP_SECERASE && !wel_q |=> state_q != fsr_pkg::ST_ERASE) // RL7
		else $error("erase started without latch");
	a_erase_lock_block: assert property (frameEnd && op_q == `FSR_OP_SECERASE && sel_q != 2'h0 &&
		securityLockBits[sel_q - 2'h1] |=> state_q != fsr_pkg::ST_ERASE) // RL11
		else $error("erase started on locked register");
	a_erase_end_wel: assert property ($fell(state_q == fsr_pkg::ST_ERASE) && !rstAccept |-> !wel_q) // RL10
		else $error("latch still set after erase");
	a_reset_defaults: assert property (rstAccept |=> !wel_q && !paused && resetBusy && wrap_q == `FSR_WRAP_RST) // RL19
		else $error("reset left volatile state");
	a_recover_refuse: assert property (resetBusy && oneByte && op_q == `FSR_OP_WREN |=> !wel_q) // RL20
		else $error("instruction taken during recovery");
	a_read_busy_ign: assert property (busy && rxEv && rxEv_q.num == `FSR_NUM_ADDR_LAST && op_q == `FSR_OP_SECREAD
		|=> !txWord_q.valid) // RL17
		else $error("read served while busy");
	a_read_wrap: assert property (loadEv && txWord_q.valid && !frameEnd && rdAddr_q[7:0] == 8'hFF
		|=> rdAddr_q[7:0] == 8'h00 && rdAddr_q[8] == $past(rdAddr_q[8])) // RL15
		else $error("read address did not wrap");

	c_resume: cover property (doResume ##1 arrayResume);
	c_erase: cover property (doErase ##1 state_q == fsr_pkg::ST_ERASE);
	c_reset: cover property (rstAccept);
	c_read: cover property (loadEv && txWord_q.valid);
endmodule
`default_nettype wire

// ===== fsr_host_model.sv
// SPI host model that sends framed flash commands and collects the answer
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
	output logic spiClk,
	output logic spiCsN,
	output logic spiMosi,
	input wire logic spiMisoO,
	input wire logic spiMisoOe
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic sawOe;
	initial
	begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
		sawOe = 1'b0;
	end
	// Serial clock only runs inside a frame
	task automatic frame();
		logic [7:0] r;
		r = 8'h00;
		rxq.delete();
		sawOe = 1'b0;
		#200;
		spiCsN = 1'b0;
		foreach (txq[i])
		begin
			for (int b = 7; b >= 0; b--)
			begin
				spiMosi = txq[i][b];
				#15;
				spiClk = 1'b1;
				r = {r[6:0], spiMisoOe ? spiMisoO : ~r[0]};
				sawOe = sawOe | spiMisoOe;
				#15;
				spiClk = 1'b0;
			end
			rxq.push_back(r);
		end
		#15;
		spiCsN = 1'b1;
		spiMosi = ~spiMosi;
		txq.delete();
	endtask
endmodule
`default_nettype wire

// ===== fsr_secreg_seq_bench.sv
// Self-checking bench for the security-register sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defs.svh"
module fsr_secreg_seq_bench;
	localparam int CYC = 50;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic spiClk, spiCsN, spiMosi, spiMisoO, spiMisoOe;
	logic pauseProgram = 1'b0;
	logic pauseErase = 1'b0;
	logic powerLoss = 1'b0;
	logic arrayOpDone = 1'b0;
	logic [2:0] securityLockBits = 3'h0;
	logic arrayResume, operationInProgress, writeEnableLatch;
	logic programPausedFlag, erasePausedFlag, resetBusy;
	logic [2:0] wrapSettingBits;
	logic [7:0] continuousReadModeBits;
	logic [7:0] mem [0:1535];
	logic write_enable_latch = 1'b0;
	int fail_count = 0;
	int n_compared = 0;
	int seed = 13;
	int cyc = 0;
	int nRes = 0;
	always #20 core_clk = ~core_clk;
	fsr_secreg_seq #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC), .RST_CYCLES(CYC)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .spiClk(spiClk), .spiCsN(spiCsN),
		.spiMosi(spiMosi), .spiMisoO(spiMisoO), .spiMisoOe(spiMisoOe),
		.pauseProgram(pauseProgram), .pauseErase(pauseErase), .powerLoss(powerLoss),
		.arrayOpDone(arrayOpDone), .securityLockBits(securityLockBits),
		.arrayResume(arrayResume), .operationInProgress(operationInProgress),
		.writeEnableLatch(writeEnableLatch), .programPausedFlag(programPausedFlag),
		.erasePausedFlag(erasePausedFlag), .wrapSettingBits(wrapSettingBits),
		.continuousReadModeBits(continuousReadModeBits), .resetBusy(resetBusy));
	fsr_host_model hostU (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMisoO(spiMisoO), .spiMisoOe(spiMisoOe));
	task results();
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (arrayResume === 1'b1)
			nRes++;
		if (cyc == 30000)
		begin
			fail_count++;
			results();
		end
	end
	function automatic int ix(input logic [23:0] a, input int i);
		return (a[13:12] - 1) * 512 + {a[8], 8'(a[7:0] + i)};
	endfunction
	task op1(input logic [7:0] op);
		hostU.txq.push_back(op);
		hostU.frame();
	endtask
	task cmd(input logic [7:0] op, input logic [23:0] a, input int n, input bit upd);
		logic [7:0] d;
		hostU.txq.push_back(op);
		hostU.txq.push_back(a[23:16]);
		hostU.txq.push_back(a[15:8]);
		hostU.txq.push_back(a[7:0]);
		for (int i = 0; i < n; i++)
		begin
			d = $random(seed);
			hostU.txq.push_back(d);
			if (upd)
				mem[ix(a, i)] = mem[ix(a, i)] & d;
		end
		hostU.frame();
	endtask
	// Waits for the busy level and counts how long it stays up
	task busy(input int e, input bit rs);
		int w, c;
		w = 0;
		c = 0;
		while ((rs ? resetBusy : operationInProgress) !== 1'b1 && w < 10)
		begin
			@(negedge core_clk);
			w++;
		end
		while ((rs ? resetBusy : operationInProgress) === 1'b1 && c < 200)
		begin
			@(negedge core_clk);
			c++;
		end
		chk("busyLen", c >= e && c <= e + 1, 1'b1);
	endtask
	task run(input logic [7:0] op, input logic [23:0] a, input int n, input int e);
		cmd(op, a, n, op == `FSR_OP_SECPROG && e > 0);
		busy(e, 1'b0);
		@(negedge core_clk);
		chk("latch", writeEnableLatch, write_enable_latch);
	endtask
	task wren();
		op1(`FSR_OP_WREN);
		write_enable_latch = 1'b1;
		busy(0, 1'b0);
		chk("latch", writeEnableLatch, 1'b1);
	endtask
	task st(input logic [7:0] op, input logic [7:0] e);
		hostU.txq.push_back(op);
		hostU.txq.push_back(8'h00);
		hostU.frame();
		chk("status", hostU.rxq[1], e);
	endtask
	task rd(input logic [23:0] a, input int n);
		cmd(`FSR_OP_SECREAD, a, n + 1, 1'b0);
		for (int i = 0; i < n; i++)
			chk("readByte", hostU.rxq[5 + i], mem[ix(a, i)]);
	endtask
	task pulse(input int k);
		@(posedge core_clk);
		{powerLoss, arrayOpDone, pauseErase, pauseProgram} <= 4'(1 << k);
		@(posedge core_clk);
		{powerLoss, arrayOpDone, pauseErase, pauseProgram} <= 4'h0;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk("contMode", continuousReadModeBits, 8'h00);
		chk("wrap", wrapSettingBits, 3'h0);
		st(`FSR_OP_RDSR1, 8'h00);
		st(`FSR_OP_RDSR2, 8'h00);
		st(`FSR_OP_RDSR3, 8'h00);
		for (int r = 1; r <= 3; r++)
		begin
			wren();
			write_enable_latch = 1'b0;
			for (int i = 0; i < 512; i++)
				mem[(r - 1) * 512 + i] = 8'hFF;
			run(`FSR_OP_SECERASE, {8'h00, 4'(r), 12'h000}, 0, CYC);
		end
		run(`FSR_OP_SECERASE, 24'h001000, 0, 0);
		wren();
		run(`FSR_OP_SECERASE, 24'h001200, 0, 0);
		run(`FSR_OP_SECERASE, 24'h101000, 0, 0);
		run(`FSR_OP_SECERASE, 24'h001000, 1, 0);
		write_enable_latch = 1'b0;
		run(`FSR_OP_SECPROG, 24'h0020FE, 4, CYC);
		run(`FSR_OP_SECPROG, 24'h002000, 2, 0);
		rd(24'h0020FC, 8);
		@(posedge core_clk);
		securityLockBits <= 3'b010;
		st(`FSR_OP_RDSR2, 8'h10);
		wren();
		run(`FSR_OP_SECERASE, 24'h002000, 0, 0);
		run(`FSR_OP_SECPROG, 24'h0020FE, 2, 0);
		rd(24'h0020FC, 8);
		cmd(`FSR_OP_SECERASE, 24'h003000, 0, 1'b0);
		cmd(`FSR_OP_SECREAD, 24'h003000, 2, 1'b0);
		chk("readOe", hostU.sawOe, 1'b0);
		write_enable_latch = 1'b0;
		repeat (80) @(negedge core_clk);
		chk("latch", writeEnableLatch, write_enable_latch);
		op1(`FSR_OP_RESUME);
		busy(0, 1'b0);
		pulse(0);
		pulse(3);
		op1(`FSR_OP_RESUME);
		busy(0, 1'b0);
		chk("progPaused", programPausedFlag, 1'b1);
		pulse(1);
		st(`FSR_OP_RDSR2, 8'h94);
		op1(`FSR_OP_RESUME);
		repeat (8) @(negedge core_clk);
		chk("resumed", {operationInProgress, programPausedFlag, erasePausedFlag}, 3'b100);
		op1(`FSR_OP_RESUME);
		repeat (8) @(negedge core_clk);
		chk("resumes", nRes, 1);
		// the op end returns the resumed op to idle here; a pause would end it too
		pulse(2);
		@(negedge core_clk);
		chk("busy", operationInProgress, 1'b0);
		wren();
		cmd(`FSR_OP_SECERASE, 24'h001000, 0, 1'b0);
		st(`FSR_OP_RDSR1, 8'h03);
		op1(`FSR_OP_ENRST);
		op1(`FSR_OP_DORST);
		busy(CYC, 1'b1);
		write_enable_latch = 1'b0;
		chk("busy", operationInProgress, 1'b0);
		chk("latch", writeEnableLatch, write_enable_latch);
		op1(`FSR_OP_ENRST);
		wren();
		op1(`FSR_OP_DORST);
		busy(0, 1'b1);
		chk("latch", writeEnableLatch, 1'b1);
		op1(`FSR_OP_ENRST);
		op1(`FSR_OP_DORST);
		repeat (10) @(negedge core_clk);
		chk("recovering", resetBusy, 1'b1);
		st(`FSR_OP_RDSR1, 8'hAA);
		chk("statusOe", hostU.sawOe, 1'b0);
		repeat (60) @(negedge core_clk);
		chk("latch", writeEnableLatch, 1'b0);
		chk("resumes", nRes, 1);
		results();
	end
endmodule
`default_nettype wire
